// file: design/slc_top.v
// Split link control channel: arbitration, routing, link setup and AXI4-Lite registers
//
// Contract
// - Near controller reaches every active far end unless it addresses this device
// - Far controller reaches only near side
// - Busy channel refuses other controllers with NACK
// - Reverse splitter uses identical access rules
// - Own bus address replaceable by register write
// - Code 01 without auto selects link A
// - Code 11 runs both links, reverse splitter
// - Restart bit pulses link reset, self-clears
// - Lock output rises once link established
// - Each packet type carries programmable origin tag
`timescale 1ns/1ps
`include "slc_map.vh"

module slc_top #(
  parameter N_TAGS = 4,
  parameter LOCK_CYCLES = `SLC_LOCK_CYCLES
) (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [6:0] addr_strap,
  input wire [2:0] ctl_start,
  input wire [2:0] ctl_stop,
  input wire [20:0] ctl_addr,
  output wire [2:0] ctl_ack,
  output wire [2:0] ctl_nack,
  output reg route_a,
  output reg route_b,
  output reg route_local,
  output reg own_sel,
  input wire link_a_up,
  input wire link_b_up,
  output reg link_restart_pulse,
  output reg link_lock_indicator,
  output reg [8*N_TAGS-1:0] packet_origin_tag
);

  // ==========================================================
  // Register state
  reg [6:0] own_bus_address;
  reg strap_loaded;
  reg [1:0] link_cfg;
  reg auto_link;
  reg [15:0] lock_cnt;
  reg owner_valid;
  reg [1:0] owner;
  reg aw_hold;
  reg w_hold;
  reg [3:0] wr_addr;
  reg [31:0] wr_data;
  reg [3:0] wr_strb;

  // ==========================================================
  // Link selection
  reg link_a_active;
  reg link_b_active;

  always @* begin
    link_a_active = 1'b1;
    link_b_active = 1'b1;
    case (link_cfg)
      `SLC_CFG_A_ONLY: begin
        link_a_active = 1'b1;
        link_b_active = auto_link;
      end
      `SLC_CFG_B_ONLY: begin
        link_a_active = auto_link;
        link_b_active = 1'b1;
      end
      `SLC_CFG_BOTH: begin
        link_a_active = 1'b1;
        link_b_active = 1'b1;
      end
      default: begin
        link_a_active = 1'b1;
        link_b_active = auto_link;
      end
    endcase
  end

  // ==========================================================
  // Arbitration
  // Source 0 is the controller on this device, 1 and 2 sit behind links A and B.
  // The roles are the same in splitter and reverse splitter use: this device is
  // always the single end facing two links.
  reg [2:0] grant;
  reg [2:0] reach;
  reg [2:0] hit;
  integer i;

  always @* begin
    grant = 3'h0;
    hit = 3'h0;
    for (i = 0; i < 3; i = i + 1) begin
      hit[i] = (ctl_addr[7*i +: 7] == own_bus_address);
    end
    if (owner_valid) begin
      // Only the holder may start again; everyone else is refused
      grant[owner] = ctl_start[owner];
    end else if (ctl_start[0]) begin
      grant[0] = 1'b1;
    end else if (ctl_start[1]) begin
      grant[1] = 1'b1;
    end else begin
      grant[2] = ctl_start[2];
    end
    // A far controller is only heard through an active, link_lock_indicator link
    reach[0] = 1'b1;
    reach[1] = link_a_active & link_lock_indicator;
    reach[2] = link_b_active & link_lock_indicator;
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_port
      slc_port_resp u_resp (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(ctl_start[g]),
        .grant(grant[g]),
        .reach(reach[g]),
        .ack(ctl_ack[g]),
        .nack(ctl_nack[g])
      );
    end
  endgenerate

  // ==========================================================
  // Ownership and routing
  always @(posedge aclk) begin
    if (!aresetn) begin
      owner_valid <= 1'b0;
      owner <= 2'h0;
      route_a <= 1'b0;
      route_b <= 1'b0;
      route_local <= 1'b0;
      own_sel <= 1'b0;
    end else if (|(grant & reach)) begin
      owner_valid <= 1'b1;
      if (grant[0]) begin
        owner <= 2'h0;
        own_sel <= hit[0];
        // Near controller goes out on every active far end unless it addresses this device
        route_a <= link_a_active & ~hit[0];
        route_b <= link_b_active & ~hit[0];
        route_local <= 1'b0;
      end else begin
        owner <= grant[1] ? 2'h1 : 2'h2;
        own_sel <= grant[1] ? hit[1] : hit[2];
        // Far controller never reaches the other far end
        route_a <= 1'b0;
        route_b <= 1'b0;
        route_local <= grant[1] ? ~hit[1] : ~hit[2];
      end
    end else if (owner_valid && ctl_stop[owner]) begin
      owner_valid <= 1'b0;
      route_a <= 1'b0;
      route_b <= 1'b0;
      route_local <= 1'b0;
      own_sel <= 1'b0;
    end
  end

  // ==========================================================
  // Link restart and lock
  wire wr_fire = aw_hold & w_hold & ~s_axi_bvalid;
  wire wr_link = wr_fire & (wr_addr == `SLC_OFS_LINK) & wr_strb[0];
  wire lock_done = (lock_cnt >= LOCK_CYCLES[15:0]);

  always @(posedge aclk) begin
    if (!aresetn) begin
      link_restart_pulse <= 1'b0;
      lock_cnt <= 16'h0000;
      link_lock_indicator <= 1'b0;
    end else begin
      // The bit never stores; it only fires one pulse
      link_restart_pulse <= wr_link & wr_data[`SLC_LINK_RESTART];
      if (link_restart_pulse) begin
        lock_cnt <= 16'h0000;
        link_lock_indicator <= 1'b0;
      end else begin
        if (!lock_done) begin
          lock_cnt <= lock_cnt + 16'h0001;
        end
        // Lock needs every active link up after the settle time
        link_lock_indicator <= lock_done & (~link_a_active | link_a_up) &
          (~link_b_active | link_b_up);
      end
    end
  end

  // ==========================================================
  // AXI4-Lite write channel
  integer b;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SLC_RESP_OKAY;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      wr_addr <= 4'h0;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      own_bus_address <= `SLC_RST_ADDR;
      strap_loaded <= 1'b0;
      link_cfg <= `SLC_RST_CFG;
      auto_link <= 1'b0;
      packet_origin_tag <= `SLC_RST_TAGS;
    end else begin
      // Strap is caught once, just after the reset release
      if (!strap_loaded) begin
        own_bus_address <= addr_strap;
        strap_loaded <= 1'b1;
      end
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        wr_addr <= {s_axi_awaddr[3:2], 2'h0};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_addr == `SLC_OFS_STAT) ? `SLC_RESP_SLVERR : `SLC_RESP_OKAY;
        case (wr_addr)
          `SLC_OFS_ADDR: begin
            if (wr_strb[0]) begin
              own_bus_address <= wr_data[6:0];
            end
          end
          `SLC_OFS_LINK: begin
            if (wr_strb[0]) begin
              link_cfg <= wr_data[`SLC_LINK_CFG_HI:`SLC_LINK_CFG_LO];
              auto_link <= wr_data[`SLC_LINK_AUTO];
            end
          end
          `SLC_OFS_TAGS: begin
            for (b = 0; b < N_TAGS && b < 4; b = b + 1) begin
              if (wr_strb[b]) begin
                packet_origin_tag[8*b +: 8] <= wr_data[8*b +: 8];
              end
            end
          end
          default: begin
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  reg [31:0] rd_mux;
  reg rd_ok;

  always @* begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    case ({s_axi_araddr[3:2], 2'h0})
      `SLC_OFS_ADDR: rd_mux = {25'h0, own_bus_address};
      `SLC_OFS_LINK: rd_mux = {29'h0, auto_link, link_cfg};
      `SLC_OFS_STAT: rd_mux = {26'h0, link_b_up, link_a_up, owner, owner_valid, link_lock_indicator};
      `SLC_OFS_TAGS: rd_mux = packet_origin_tag[31:0];
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SLC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? `SLC_RESP_OKAY : `SLC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// file: design/slc_map.vh
// Register offsets, field positions, reset values and timing counts of the split link control block
`ifndef SLC_MAP_VH
`define SLC_MAP_VH

// ==========================================================
// Register byte offsets
`define SLC_OFS_ADDR 4'h0
`define SLC_OFS_LINK 4'h4
`define SLC_OFS_STAT 4'h8
`define SLC_OFS_TAGS 4'hc

// ==========================================================
// Link control fields
`define SLC_LINK_CFG_LO 0
`define SLC_LINK_CFG_HI 1
`define SLC_LINK_AUTO 2
`define SLC_LINK_RESTART 3

// ==========================================================
// Link configuration codes
`define SLC_CFG_A_ONLY 2'h1
`define SLC_CFG_B_ONLY 2'h2
`define SLC_CFG_BOTH 2'h3

// ==========================================================
// Reset values
`define SLC_RST_ADDR 7'h40
`define SLC_RST_CFG 2'h3
`define SLC_RST_TAGS 32'h03020100

// ==========================================================
// Timing
`define SLC_CLK_NS 40
`define SLC_LOCK_TIME_NS 2000
`define SLC_LOCK_CYCLES ((`SLC_LOCK_TIME_NS + `SLC_CLK_NS - 1) / `SLC_CLK_NS)

// ==========================================================
// Bus answers
`define SLC_RESP_OKAY 2'h0
`define SLC_RESP_SLVERR 2'h2

`endif

// file: design/slc_port_resp.v
// Per-controller acknowledge and refusal pulse generator
`timescale 1ns/1ps

module slc_port_resp (
  input wire aclk,
  input wire aresetn,
  input wire start,
  input wire grant,
  input wire reach,
  output reg ack,
  output reg nack
);

  // ==========================================================
  // Answer pulses, one cycle after the start
  always @(posedge aclk) begin
    if (!aresetn) begin
      ack <= 1'b0;
      nack <= 1'b0;
    end else begin
      ack <= start & grant & reach;
      // Refused when another controller owns or wins the channel or the requester is unreachable (far link not active and locked)
      nack <= start & ~(grant & reach);
    end
  end

endmodule

// file: dv/slc_far_model.sv
// Far-end link devices: link up levels that drop while retraining
`timescale 1ns/1ps
module slc_far_model #(
  parameter DOWN = 2
) (
  input wire aclk,
  input wire present_a,
  input wire present_b,
  input wire link_restart_pulse,
  output wire link_a_up,
  output wire link_b_up
);
  // ==========================================================
  // Retraining
  reg [31:0] dn = 32'h0;
  // A restart makes both far ends retrain, so a slow far side reads down for a while
  always @(posedge aclk) begin
    if (link_restart_pulse) begin
      dn <= DOWN;
    end else if (dn != 32'h0) begin
      dn <= dn - 32'h1;
    end
  end
  assign link_a_up = present_a && dn == 32'h0;
  assign link_b_up = present_b && dn == 32'h0;
endmodule

// file: dv/slc_top_properties.sv
// Assertion checker for the split link control block
`timescale 1ns/1ps
module slc_checker (
  input wire aclk,
  input wire aresetn,
  input wire [2:0] ctl_start,
  input wire [2:0] ctl_ack,
  input wire [2:0] ctl_nack,
  input wire route_a,
  input wire route_b,
  input wire link_restart_pulse,
  input wire link_lock_indicator,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp
);
  // ==========================================================
  // Properties
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  start_answer_a: assert property ((ctl_ack | ctl_nack) == $past(ctl_start))
    else $error("start not answered next cycle");
  one_grant_a: assert property ($onehot0(ctl_ack) && (ctl_ack & ctl_nack) == 3'h0)
    else $error("channel granted twice");
  far_lock_a: assert property (|ctl_ack[2:1] |-> $past(link_lock_indicator))
    else $error("far controller granted without lock");
  a_side_only_a: assert property (ctl_ack[1] |-> !route_b)
    else $error("far controller reached other far end");
  b_side_only_a: assert property (ctl_ack[2] |-> !route_a)
    else $error("far controller reached other far end");
  pulse_single_a: assert property (link_restart_pulse |=> !link_restart_pulse)
    else $error("restart pulse longer than one cycle");
  // Only a lower bound on the lock delay: slow far ends may stretch it
  lock_drop_a: assert property (link_restart_pulse |=> !link_lock_indicator [*4])
    else $error("lock kept through restart");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  cover property (ctl_nack[1]);
  cover property (ctl_ack[2]);
  cover property (link_restart_pulse);
  cover property (s_axi_bvalid && !s_axi_bready);
endmodule
bind slc_top slc_checker u_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .ctl_start(ctl_start),
  .ctl_ack(ctl_ack),
  .ctl_nack(ctl_nack),
  .route_a(route_a),
  .route_b(route_b),
  .link_restart_pulse(link_restart_pulse),
  .link_lock_indicator(link_lock_indicator),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp)
);

// file: dv/test_split_link_control_channel.sv
// Self-checking bench for the split link control block
`timescale 1ns/1ps
module test_split_link_control_channel;
  // ==========================================================
  // Signals
  localparam LOCK = 6;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  // Write answers are taken one cycle late so the answer must stand while waiting
  reg s_axi_bready = 1'b0, s_axi_rready = 1'b1;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [2:0] ctl_start = 3'h0, ctl_stop = 3'h0;
  reg [20:0] ctl_addr = {7'h12, 7'h11, 7'h10};
  wire [6:0] addr_strap = 7'h2a;
  reg present_a = 1'b1, present_b = 1'b1;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, packet_origin_tag;
  wire [2:0] ctl_ack, ctl_nack;
  wire route_a, route_b, route_local, own_sel, link_a_up, link_b_up, link_restart_pulse, link_lock_indicator;
  integer error_cnt = 0, tests_run = 0, cyc = 0, pulse_cnt = 0, lock_wait = 0, p0 = 0;
  initial forever #20 aclk = ~aclk;
  slc_top #(.LOCK_CYCLES(LOCK)) uut (.*);
  slc_far_model #(.DOWN(2)) u_far (.*);
  // ==========================================================
  // Monitor and timeout
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (link_restart_pulse) begin
      pulse_cnt <= pulse_cnt + 1;
      lock_wait <= 0;
    end else if (!link_lock_indicator) begin
      lock_wait <= lock_wait + 1;
    end
    if (cyc == 5000) begin
      error_cnt = error_cnt + 1;
      summarize;
    end
  end
  // ==========================================================
  // Tasks
  task chk(input [31:0] got, input [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input [3:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    @(posedge aclk);
    while (!s_axi_bvalid) begin
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      @(posedge aclk);
    end
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
  endtask
  task rd(input [3:0] a, input [31:0] exp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    @(posedge aclk);
    while (!s_axi_rvalid) begin
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      @(posedge aclk);
    end
    chk({s_axi_rresp, s_axi_rdata[29:0]}, exp);
  endtask
  task go(input [2:0] m, input [5:0] exp);
    @(posedge aclk);
    ctl_start <= m;
    @(posedge aclk);
    ctl_start <= 3'h0;
    #1;
    chk({ctl_ack, ctl_nack}, exp);
  endtask
  task stop(input [2:0] m);
    @(posedge aclk);
    ctl_stop <= m;
    @(posedge aclk);
    ctl_stop <= 3'h0;
    @(posedge aclk);
  endtask
  // Every configuration change is followed by a restart and a wait for lock
  task link_set(input [1:0] cfg);
    p0 = pulse_cnt;
    wr(4'h4, {28'h0, 2'h2, cfg}, 4'h1, 2'h0);
    while (pulse_cnt == p0 || !link_lock_indicator) @(posedge aclk);
    chk(lock_wait >= LOCK, 32'h1);
    chk(pulse_cnt, p0 + 1);
    rd(4'h4, {30'h0, cfg});
  endtask
  task summarize;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================================
  // Sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    while (!link_lock_indicator) @(posedge aclk);
    rd(4'h0, 32'h2a);
    rd(4'hc, 32'h03020100);
    wr(4'h8, 32'h0, 4'hf, 2'h2);
    rd(4'h8, 32'h31);
    link_set(2'h1);
    go(3'h1, 6'h08);
    chk({route_a, route_b, route_local, own_sel}, 4'h8);
    go(3'h2, 6'h02);
    stop(3'h1);
    go(3'h4, 6'h04);
    link_set(2'h3);
    go(3'h1, 6'h08);
    chk({route_a, route_b, route_local, own_sel}, 4'hc);
    go(3'h2, 6'h02);
    stop(3'h1);
    go(3'h2, 6'h10);
    chk({route_a, route_b, route_local, own_sel}, 4'h2);
    go(3'h4, 6'h04);
    stop(3'h2);
    go(3'h4, 6'h20);
    chk({route_a, route_b, route_local, own_sel}, 4'h2);
    stop(3'h4);
    go(3'h6, 6'h14);
    stop(3'h2);
    wr(4'h0, 32'h55, 4'h1, 2'h0);
    rd(4'h0, 32'h55);
    ctl_addr[6:0] <= 7'h55;
    go(3'h1, 6'h08);
    chk(own_sel, 32'h1);
    stop(3'h1);
    ctl_addr[6:0] <= 7'h2a;
    go(3'h1, 6'h08);
    chk(own_sel, 32'h0);
    stop(3'h1);
    present_b <= 1'b0;
    go(3'h4, 6'h04);
    present_b <= 1'b1;
    link_set(2'h2);
    go(3'h2, 6'h02);
    go(3'h4, 6'h20);
    stop(3'h4);
    wr(4'hc, 32'h0a0b0c0d, 4'h5, 2'h0);
    rd(4'hc, 32'h030b010d);
    chk(packet_origin_tag, 32'h030b010d);
    summarize;
  end
endmodule
